// File: verilog/effective_address_generator.sv
// Module: effective-address generation for all addressing modes
`timescale 1ns/10ps
`default_nettype none
module effective_address_generator (
  input  wire logic                        core_clk,
  input  wire logic                        reset_n,
  input  wire logic                        req_valid,
  input  wire ea_pkg::addr_mode_e          mode,
  input  wire ea_pkg::index_sel_e          index_sel,
  input  wire ea_pkg::special_e            special,
  input  wire logic [ea_pkg::OPND_W-1:0]   operand_field,
  input  wire logic [ea_pkg::ADDR_W-1:0]   operand_location,
  input  wire logic                        branch_taken,
  input  wire logic [ea_pkg::WORD_W-1:0]   program_counter,
  input  wire logic [ea_pkg::BANK_W-1:0]   program_bank_field,
  input  wire logic [ea_pkg::BANK_W-1:0]   extended_bank_field,
  input  wire logic [ea_pkg::BANK_W-1:0]   x_bank_field,
  input  wire logic [ea_pkg::BANK_W-1:0]   y_bank_field,
  input  wire logic [ea_pkg::WORD_W-1:0]   first_index_register,
  input  wire logic [ea_pkg::WORD_W-1:0]   second_index_register,
  input  wire logic [ea_pkg::WORD_W-1:0]   accumulator_e,
  input  wire logic [ea_pkg::WORD_W-1:0]   add_target,
  input  wire logic [ea_pkg::BANK_W-1:0]   z_reset_bank,
  input  wire logic [ea_pkg::WORD_W-1:0]   z_reset_index,
  input  wire logic                        z_write,
  input  wire logic [ea_pkg::ADDR_W-1:0]   z_write_value,
  output logic                             ready,
  output logic                             ea_valid,
  output logic      [ea_pkg::ADDR_W-1:0]   effective_address,
  output logic                             bank_crossed,
  output logic                             operand_fetch,
  output logic                             vector_area_hit,
  output logic                             branch_go,
  output logic                             x_index_write,
  output logic      [ea_pkg::WORD_W-1:0]   x_index_next,
  output logic                             add_result_valid,
  output logic      [ea_pkg::WORD_W-1:0]   add_result,
  output logic                             mac_offsets_valid,
  output logic      [3:0]                  mac_x_offset,
  output logic      [3:0]                  mac_y_offset,
  output logic                             stack_mask_valid,
  output logic      [7:0]                  stack_mask,
  output logic      [ea_pkg::BANK_W-1:0]   z_bank_field,
  output logic      [ea_pkg::WORD_W-1:0]   third_index_register
);
  import ea_pkg::*;

  typedef struct packed {
    logic              z_ready;
    logic [BANK_W-1:0] z_bank;
    logic [WORD_W-1:0] z_index;
    logic              ea_valid;
    logic [ADDR_W-1:0] ea;
    logic              crossed;
    logic              fetch;
    logic              vector_hit;
    logic              branch_go;
    logic              x_wr;
    logic [WORD_W-1:0] x_next;
    logic              add_valid;
    logic [WORD_W-1:0] add_res;
    logic              mac_valid;
    logic [3:0]        mac_x;
    logic [3:0]        mac_y;
    logic              mask_valid;
    logic [7:0]        mask;
  } state_s;

  state_s st_q;
  state_s st_d;

  logic              taken;
  logic [ADDR_W-1:0] index_base;
  logic [ADDR_W-1:0] pc_base;
  logic [ADDR_W-1:0] e_ext;
  logic [ADDR_W-1:0] word_ext;
  logic [ADDR_W-1:0] byte_ext;

  ea_add_if main_bus ();
  ea_add_if post_bus ();

  ea_adder u_main_adder (
    .bus (main_bus)
  );

  ea_adder u_post_adder (
    .bus (post_bus)
  );

  sign_ext #(.IN_W(WORD_W), .OUT_W(ADDR_W)) u_e_ext (
    .value_in  (accumulator_e),
    .value_out (e_ext)
  );

  sign_ext #(.IN_W(WORD_W), .OUT_W(ADDR_W)) u_word_ext (
    .value_in  (operand_field[WORD_W-1:0]),
    .value_out (word_ext)
  );

  sign_ext #(.IN_W(8), .OUT_W(ADDR_W)) u_byte_ext (
    .value_in  (operand_field[7:0]),
    .value_out (byte_ext)
  );

  // Requests are dropped until the Z vectors have been taken
  assign taken = req_valid && st_q.z_ready;

  assign pc_base = {program_bank_field, program_counter}; // RULE_19

  always_comb begin
    case (index_sel)
      index_y: index_base = {y_bank_field, second_index_register}; // RULE_19
      index_z: index_base = {st_q.z_bank, st_q.z_index};
      default: index_base = {x_bank_field, first_index_register};
    endcase
  end

  // Adder operands by mode
  always_comb begin
    main_bus.base = index_base;
    main_bus.offset = '0;
    post_bus.base = {x_bank_field, first_index_register};
    post_bus.offset = byte_ext; // RULE_15
    case (mode)
      short_unsigned_indexed_mode: begin
        main_bus.offset = {12'h000, operand_field[7:0]}; // RULE_09
      end
      word_signed_indexed_mode: begin
        main_bus.offset = word_ext; // RULE_10
      end
      long_signed_indexed_mode: begin
        // Top nibble of the 24-bit field is zero padding
        main_bus.offset = operand_field[ADDR_W-1:0]; // RULE_11
      end
      accumulator_offset_mode: begin
        main_bus.offset = e_ext; // RULE_13
      end
      short_relative_mode: begin
        main_bus.base = pc_base;
        main_bus.offset = byte_ext; // RULE_14
      end
      long_relative_mode: begin
        main_bus.base = pc_base;
        main_bus.offset = word_ext; // RULE_14
      end
      default: begin
        main_bus.offset = '0;
      end
    endcase
  end

  always_comb begin
    st_d = st_q;
    st_d.ea_valid = 1'b0;
    st_d.x_wr = 1'b0;
    st_d.add_valid = 1'b0;
    st_d.mac_valid = 1'b0;
    st_d.mask_valid = 1'b0;
    if (!st_q.z_ready) begin
      // Vectors sampled on the first edge after release, never under reset
      st_d.z_bank = z_reset_bank; // RULE_17
      st_d.z_index = z_reset_index; // RULE_17
      st_d.z_ready = 1'b1;
    end else begin
      if (z_write) begin
        st_d.z_bank = z_write_value[ADDR_W-1:BANK_LSB];
        st_d.z_index = z_write_value[WORD_W-1:0];
      end
      if (taken) begin
        st_d.ea_valid = 1'b1;
        st_d.fetch = 1'b1;
        st_d.crossed = 1'b0;
        st_d.branch_go = 1'b0;
        case (mode)
          byte_immediate_mode: begin
            st_d.ea = operand_location; // RULE_03
            case (special)
              add_immediate: begin
                st_d.add_valid = 1'b1;
                st_d.add_res = add_target + byte_ext[WORD_W-1:0]; // RULE_04
              end
              multiply_accumulate: begin
                st_d.mac_valid = 1'b1;
                st_d.mac_x = operand_field[MAC_X_LSB+3:MAC_X_LSB]; // RULE_05
                st_d.mac_y = operand_field[MAC_Y_LSB+3:MAC_Y_LSB]; // RULE_05
              end
              push_pull_multiple: begin
                st_d.mask_valid = 1'b1;
                st_d.mask = operand_field[7:0]; // RULE_06
              end
              default: begin
                st_d.add_valid = 1'b0;
              end
            endcase
          end
          word_immediate_mode: begin
            st_d.ea = operand_location; // RULE_03
          end
          bank_extended_mode: begin
            st_d.ea = {extended_bank_field, operand_field[WORD_W-1:0]}; // RULE_07
          end
          full_absolute_mode: begin
            st_d.ea = operand_field[ADDR_W-1:0]; // RULE_08
          end
          short_unsigned_indexed_mode,
          word_signed_indexed_mode,
          long_signed_indexed_mode,
          accumulator_offset_mode: begin
            st_d.ea = main_bus.sum; // RULE_01
            st_d.crossed = main_bus.crossed; // RULE_02
          end
          implied_mode: begin
            st_d.ea = '0;
            st_d.fetch = 1'b0; // RULE_12
          end
          post_modified_mode: begin
            st_d.ea = {x_bank_field, first_index_register}; // RULE_15
            st_d.x_wr = 1'b1;
            // Bank field left alone; only the index moves
            st_d.x_next = post_bus.sum[WORD_W-1:0]; // RULE_15
          end
          short_relative_mode,
          long_relative_mode: begin
            st_d.fetch = 1'b0;
            if (branch_taken) begin
              st_d.ea = main_bus.sum; // RULE_14
              st_d.crossed = main_bus.crossed;
              st_d.branch_go = 1'b1;
            end else begin
              st_d.ea = pc_base;
            end
          end
          default: begin
            st_d.ea_valid = 1'b0;
            st_d.fetch = 1'b0;
          end
        endcase
        // Flags data access into the vector table
        st_d.vector_hit = st_d.fetch && (st_d.ea < VECTOR_LIMIT); // RULE_16
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= '0;
      st_q.z_bank <= Z_BANK_RESET;
      st_q.z_index <= Z_INDEX_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  assign ready = st_q.z_ready;
  assign ea_valid = st_q.ea_valid;
  assign effective_address = st_q.ea;
  assign bank_crossed = st_q.crossed;
  assign operand_fetch = st_q.fetch;
  assign vector_area_hit = st_q.vector_hit;
  assign branch_go = st_q.branch_go;
  assign x_index_write = st_q.x_wr;
  assign x_index_next = st_q.x_next;
  assign add_result_valid = st_q.add_valid;
  assign add_result = st_q.add_res;
  assign mac_offsets_valid = st_q.mac_valid;
  assign mac_x_offset = st_q.mac_x;
  assign mac_y_offset = st_q.mac_y;
  assign stack_mask_valid = st_q.mask_valid;
  assign stack_mask = st_q.mask;
  assign z_bank_field = st_q.z_bank;
  assign third_index_register = st_q.z_index;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  imm_location_a: assert property ( // RULE_03
    taken && (mode == word_immediate_mode) |=> ea_valid && operand_fetch
      && (effective_address == $past(operand_location)))
    else $error("immediate address is not the operand location");

  ext_concat_a: assert property ( // RULE_07
    taken && (mode == bank_extended_mode)
    |=> effective_address == {$past(extended_bank_field), $past(operand_field[15:0])})
    else $error("extended address not bank over operand word");

  abs_address_a: assert property ( // RULE_08
    taken && (mode == full_absolute_mode)
    |=> effective_address == $past(operand_field[19:0]))
    else $error("absolute address wrong");

  short_index_a: assert property ( // RULE_09
    taken && (mode == short_unsigned_indexed_mode) && (index_sel == index_y)
    |=> effective_address == ({$past(y_bank_field), $past(second_index_register)}
      + {12'h000, $past(operand_field[7:0])}))
    else $error("short indexed sum wrong");

  word_index_a: assert property ( // RULE_10
    taken && (mode == word_signed_indexed_mode) && (index_sel == index_x)
    |=> effective_address == ({$past(x_bank_field), $past(first_index_register)}
      + {{4{$past(operand_field[15])}}, $past(operand_field[15:0])}))
    else $error("word indexed sum wrong");

  acc_offset_a: assert property ( // RULE_13
    taken && (mode == accumulator_offset_mode) && (index_sel == index_z)
    |=> effective_address == ({$past(st_q.z_bank), $past(st_q.z_index)}
      + {{4{$past(accumulator_e[15])}}, $past(accumulator_e)}))
    else $error("accumulator offset sum wrong");

  no_fetch_a: assert property ( // RULE_12
    taken && (mode == implied_mode) |=> ea_valid && !operand_fetch && !vector_area_hit)
    else $error("implied mode requested an operand fetch");

  branch_target_a: assert property ( // RULE_14
    taken && (mode == short_relative_mode) && branch_taken
    |=> branch_go && (effective_address == ({$past(program_bank_field),
      $past(program_counter)} + {{12{$past(operand_field[7])}}, $past(operand_field[7:0])})))
    else $error("short branch target wrong");

  post_modify_a: assert property ( // RULE_15
    taken && (mode == post_modified_mode)
    |=> x_index_write && (effective_address[15:0] == $past(first_index_register))
      && (x_index_next == $past(first_index_register)
        + {{8{$past(operand_field[7])}}, $past(operand_field[7:0])}))
    else $error("post-modified index wrong");

  add_imm_a: assert property ( // RULE_04
    taken && (mode == byte_immediate_mode) && (special == add_immediate)
    |=> add_result_valid && (add_result == $past(add_target)
      + {{8{$past(operand_field[7])}}, $past(operand_field[7:0])}))
    else $error("add immediate not sign extended");

  mac_split_a: assert property ( // RULE_05
    taken && (mode == byte_immediate_mode) && (special == multiply_accumulate)
    |=> mac_offsets_valid && ({mac_x_offset, mac_y_offset} == $past(operand_field[7:0])))
    else $error("mac offsets not split from immediate");

  mask_pass_a: assert property ( // RULE_06
    taken && (mode == byte_immediate_mode) && (special == push_pull_multiple)
    |=> stack_mask_valid && (stack_mask == $past(operand_field[7:0])))
    else $error("stack mask wrong");

  vector_flag_a: assert property ( // RULE_16
    ea_valid && operand_fetch |-> vector_area_hit == (effective_address < VECTOR_LIMIT))
    else $error("vector area flag wrong");

  z_vector_a: assert property ( // RULE_17
    $rose(ready) |-> (z_bank_field == $past(z_reset_bank))
      && (third_index_register == $past(z_reset_index)))
    else $error("z registers not loaded from reset vectors");

  bank_keep_a: assert property ( // RULE_02
    ready && !z_write ##1 bank_crossed |-> $stable(z_bank_field))
    else $error("bank crossing changed a stored bank field");

  cross_cov: cover property (taken && (mode == word_signed_indexed_mode) ##1 bank_crossed);
  branch_cov: cover property (taken && (mode == long_relative_mode) && branch_taken);
  post_cov: cover property (taken && (mode == post_modified_mode) ##1 x_index_write);
  vector_cov: cover property (vector_area_hit);

endmodule // effective_address_generator
`default_nettype wire

// File: verilog/ea_pkg.sv
// Package: widths, modes, reset values and limits of the effective-address generator
// What this block does
// RULE_01: Every mode yields 16-bit low address joined with 4-bit bank into 20 bits.
// RULE_02: Bank crossings move only effective-address bits 19:16; stored bank fields stay.
// RULE_03: Byte and word immediate: effective address is the operand's own location.
// RULE_04: Add-immediate forms sign-extend byte immediate to 16 bits, then add to target.
// RULE_05: Multiply-accumulate splits byte immediate into two signed 4-bit index offsets.
// RULE_06: Push and pull multiple use byte immediate as a register selection mask.
// RULE_07: Bank extended mode: extended bank field above the 16-bit operand word.
// RULE_08: Full absolute mode takes a 20-bit address from a 24-bit operand field.
// RULE_09: Short indexed: unsigned byte offset added to bank field and index register.
// RULE_10: Word indexed: signed word offset added to bank field and index register.
// RULE_11: Long indexed: signed 20-bit offset from 24-bit field added to index.
// RULE_12: Implied mode fetches no operand from memory.
// RULE_13: Accumulator offset: E sign-extended to 20 bits plus index; D untouched.
// RULE_14: Taken branches add signed byte or word offset to program bank and counter.
// RULE_15: Post-modified mode uses X bank and index first, then adds signed byte.
// RULE_16: Lowest 512 bytes of bank 0 are reserved for exception vectors.
// RULE_17: Z bank field and Z index are loaded from reset vectors after reset.
// RULE_18: Address sums wrap modulo 2**20; signed offsets sign-extend to 20 bits.
// RULE_19: Address layout: bank in bits 19:16, byte address in bits 15:0.
package ea_pkg;

  localparam int ADDR_W = 20;
  localparam int BANK_W = 4;
  localparam int WORD_W = 16;
  localparam int OPND_W = 24;
  localparam int BANK_LSB = 16;
  localparam int MAC_X_LSB = 4;
  localparam int MAC_Y_LSB = 0;
  localparam logic [ADDR_W-1:0] VECTOR_LIMIT = 20'h00200;
  localparam logic [BANK_W-1:0] Z_BANK_RESET = 4'h0;
  localparam logic [WORD_W-1:0] Z_INDEX_RESET = 16'h0000;

  typedef enum logic [3:0] {
    byte_immediate_mode         = 4'h0,
    word_immediate_mode         = 4'h1,
    bank_extended_mode          = 4'h2,
    full_absolute_mode          = 4'h3,
    short_unsigned_indexed_mode = 4'h4,
    word_signed_indexed_mode    = 4'h5,
    long_signed_indexed_mode    = 4'h6,
    implied_mode                = 4'h7,
    accumulator_offset_mode     = 4'h8,
    post_modified_mode          = 4'h9,
    short_relative_mode         = 4'ha,
    long_relative_mode          = 4'hb
  } addr_mode_e;

  typedef enum logic [1:0] {
    index_x = 2'h0,
    index_y = 2'h1,
    index_z = 2'h2
  } index_sel_e;

  typedef enum logic [1:0] {
    plain_immediate      = 2'h0,
    add_immediate        = 2'h1,
    multiply_accumulate  = 2'h2,
    push_pull_multiple   = 2'h3
  } special_e;

endpackage

// File: verilog/ea_add_if.sv
// Interface: operands and result of one 20-bit address adder
`timescale 1ns/10ps
`default_nettype none
interface ea_add_if;
  logic [19:0] base;
  logic [19:0] offset;
  logic [19:0] sum;
  logic        crossed;
  modport adder (input base, input offset, output sum, output crossed);
  modport user  (output base, output offset, input sum, input crossed);
endinterface : ea_add_if
`default_nettype wire

// File: verilog/ea_adder.sv
// Module: 20-bit wrapping address adder with bank-crossing flag
`timescale 1ns/10ps
`default_nettype none
module ea_adder (
  ea_add_if.adder bus
);
  // Carry out of bit 19 is dropped on purpose
  assign bus.sum = bus.base + bus.offset; // RULE_18
  assign bus.crossed = (bus.sum[19:16] != bus.base[19:16]); // RULE_02
endmodule // ea_adder
`default_nettype wire

// File: verilog/sign_ext.sv
// Module: parameterised sign extension
`timescale 1ns/10ps
`default_nettype none
module sign_ext #(
  parameter int IN_W  = 8,
  parameter int OUT_W = 20
) (
  input  wire logic [IN_W-1:0]  value_in,
  output logic      [OUT_W-1:0] value_out
);
  assign value_out = {{(OUT_W-IN_W){value_in[IN_W-1]}}, value_in}; // RULE_18
endmodule // sign_ext
`default_nettype wire

// File: dv/reg_file_model.sv
// Partner model: register file and program counter that feed the address generator
`timescale 1ns/10ps
`default_nettype none
module reg_file_model (
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  input  wire logic        load,
  input  wire logic [95:0] load_value,
  input  wire logic        x_index_write,
  input  wire logic [15:0] x_index_next,
  output logic      [15:0] program_counter,
  output logic      [3:0]  program_bank_field,
  output logic      [3:0]  extended_bank_field,
  output logic      [3:0]  x_bank_field,
  output logic      [3:0]  y_bank_field,
  output logic      [15:0] first_index_register,
  output logic      [15:0] second_index_register,
  output logic      [15:0] accumulator_e,
  output logic      [15:0] add_target
);
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      {program_counter, program_bank_field, extended_bank_field, x_bank_field, y_bank_field,
       first_index_register, second_index_register, accumulator_e, add_target} <= 96'h0;
    end else if (load) begin
      {program_counter, program_bank_field, extended_bank_field, x_bank_field, y_bank_field,
       first_index_register, second_index_register, accumulator_e, add_target} <= load_value;
    end else if (x_index_write) begin
      // Bank field never written back: only the 16-bit index moves
      first_index_register <= x_index_next;
    end
  end
endmodule // reg_file_model
`default_nettype wire

// File: dv/tb_effective_address_generator.sv
// Testbench: random and corner-case checks of the effective-address generator
`timescale 1ns/10ps
`default_nettype none
module tb_effective_address_generator;
  import ea_pkg::*;
  logic        core_clk, reset_n, req_valid, branch_taken, z_write, load;
  addr_mode_e  mode;
  index_sel_e  index_sel;
  special_e    special;
  logic [23:0] operand_field;
  logic [19:0] operand_location, z_write_value, z_model, effective_address, last_ea;
  logic [95:0] load_value;
  logic [15:0] program_counter, first_index_register, second_index_register, accumulator_e;
  logic [15:0] add_target, z_reset_index, x_index_next, add_result, third_index_register;
  logic [3:0]  program_bank_field, extended_bank_field, x_bank_field, y_bank_field;
  logic [3:0]  z_reset_bank, z_bank_field, mac_x_offset, mac_y_offset;
  logic [7:0]  stack_mask;
  logic        ready, ea_valid, bank_crossed, operand_fetch, vector_area_hit, branch_go;
  logic        x_index_write, add_result_valid, mac_offsets_valid, stack_mask_valid;
  int          seed, errors, checked;

  effective_address_generator u_effective_address_generator (.core_clk, .reset_n, .req_valid,
    .mode, .index_sel, .special, .operand_field, .operand_location, .branch_taken,
    .program_counter, .program_bank_field, .extended_bank_field, .x_bank_field, .y_bank_field,
    .first_index_register, .second_index_register, .accumulator_e, .add_target, .z_reset_bank,
    .z_reset_index, .z_write, .z_write_value, .ready, .ea_valid, .effective_address,
    .bank_crossed, .operand_fetch, .vector_area_hit, .branch_go, .x_index_write, .x_index_next,
    .add_result_valid, .add_result, .mac_offsets_valid, .mac_x_offset, .mac_y_offset,
    .stack_mask_valid, .stack_mask, .z_bank_field, .third_index_register);

  reg_file_model u_reg_file_model (.core_clk, .reset_n, .load, .load_value, .x_index_write,
    .x_index_next, .program_counter, .program_bank_field, .extended_bank_field, .x_bank_field,
    .y_bank_field, .first_index_register, .second_index_register, .accumulator_e, .add_target);

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  task automatic finish_test;
    $display("checks %0d, mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask

  // Returns {crossing checked, fetch, crossed, address}
  function automatic logic [22:0] ea_calc(input logic [3:0] m, input logic [1:0] ix,
      input logic [23:0] op, input logic bt, input logic [19:0] loc, input logic [95:0] r);
    logic [15:0] pc, xi, yi, e;
    logic [3:0]  pk, ek, xk, yk;
    logic [19:0] b, o, s;
    logic        f, c;
    {pc, pk, ek, xk, yk, xi, yi, e} = r[95:16];
    b = (ix == 2'h1) ? {yk, yi} : (ix == 2'h2) ? z_model : {xk, xi};
    o = 20'h0;
    f = 1'b1;
    c = 1'b0;
    case (m)
      4'h0, 4'h1: b = loc;
      4'h2: b = {ek, op[15:0]};
      4'h3: b = op[19:0];
      4'h4: {c, o} = {1'b1, 12'h0, op[7:0]};
      4'h5: {c, o} = {1'b1, {4{op[15]}}, op[15:0]};
      4'h6: {c, o} = {1'b1, op[19:0]};
      4'h7: {f, b} = 21'h0;
      4'h8: {c, o} = {1'b1, {4{e[15]}}, e};
      4'h9: b = {xk, xi};
      default: begin
        {f, c, b} = {1'b0, bt, pk, pc};
        o = !bt ? 20'h0 : (m == 4'ha) ? {{12{op[7]}}, op[7:0]} : {{4{op[15]}}, op[15:0]};
      end
    endcase
    s = b + o;
    return {c, f, c && (s[19:16] != b[19:16]), s};
  endfunction

  task automatic run_req(input logic [3:0] m, input logic [1:0] ix, input logic [1:0] sp,
      input logic [23:0] op, input logic bt, input logic [19:0] loc, input logic [95:0] r);
    logic [22:0] x;
    x = ea_calc(m, ix, op, bt, loc, r);
    @(posedge core_clk);
    load <= 1'b1;
    load_value <= r;
    #1;
    chk("ea_valid pulse", ea_valid, 0);
    chk("effective_address held", effective_address, last_ea);
    @(posedge core_clk);
    load <= 1'b0;
    req_valid <= 1'b1;
    mode <= addr_mode_e'(m);
    index_sel <= index_sel_e'(ix);
    special <= special_e'(sp);
    operand_field <= op;
    branch_taken <= bt;
    operand_location <= loc;
    @(posedge core_clk);
    req_valid <= 1'b0;
    #1;
    chk("ea_valid", ea_valid, m < 4'hc);
    if (m < 4'hc) begin
      last_ea = x[19:0];
      chk("effective_address", effective_address, x[19:0]);
      chk("operand_fetch", operand_fetch, x[21]);
      chk("vector_area_hit", vector_area_hit, x[21] && x[19:0] < 20'h00200);
      if (x[22]) chk("bank_crossed", bank_crossed, x[20]);
      if (m >= 4'ha) chk("branch_go", branch_go, bt);
    end
    chk("z bank kept", {z_bank_field, third_index_register}, z_model);
    chk("x_index_write", x_index_write, m == 4'h9);
    if (m == 4'h9)
      chk("x_index_next", x_index_next, 16'(r[63:48] + {{8{op[7]}}, op[7:0]}));
    chk("add_result_valid", add_result_valid, m == 4'h0 && sp == 2'h1);
    chk("mac_offsets_valid", mac_offsets_valid, m == 4'h0 && sp == 2'h2);
    chk("stack_mask_valid", stack_mask_valid, m == 4'h0 && sp == 2'h3);
    if (m == 4'h0 && sp == 2'h1)
      chk("add_result", add_result, 16'(r[15:0] + {{8{op[7]}}, op[7:0]}));
    if (m == 4'h0 && sp == 2'h2)
      chk("mac offsets", {mac_x_offset, mac_y_offset}, op[7:0]);
    if (m == 4'h0 && sp == 2'h3) chk("stack_mask", stack_mask, op[7:0]);
  endtask

  task automatic rand_req(input logic [3:0] m, input logic [1:0] sp);
    run_req(m, 2'($random(seed)), sp, 24'($random(seed)), 1'($random(seed)),
            20'($random(seed)), {$random(seed), $random(seed), $random(seed)});
  endtask

  task automatic z_wr(input logic [19:0] v);
    @(posedge core_clk);
    z_write <= 1'b1;
    z_write_value <= v;
    @(posedge core_clk);
    z_write <= 1'b0;
    z_model = v;
    #1;
    chk("z write", {z_bank_field, third_index_register}, v);
  endtask

  initial begin
    repeat (5000) @(posedge core_clk);
    errors++;
    finish_test();
  end

  initial begin
    seed = 44521;
    errors = 0;
    checked = 0;
    last_ea = 20'h0;
    reset_n = 1'b0;
    req_valid = 1'b1;
    {branch_taken, z_write, load} = 3'h0;
    mode = bank_extended_mode;
    index_sel = index_x;
    special = plain_immediate;
    {operand_field, operand_location, z_write_value, load_value} = 160'h0;
    z_reset_bank = 4'h7;
    z_reset_index = 16'hc35a;
    z_model = {z_reset_bank, z_reset_index};
    repeat (5) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    req_valid <= 1'b0;
    #1;
    // A request seen at the Z-load edge must be dropped
    chk("early request", ea_valid, 0);
    chk("ready", ready, 1);
    chk("z reset load", {z_bank_field, third_index_register}, z_model);
    @(posedge core_clk);
    #1;
    chk("idle after reset", ea_valid, 0);
    $display("test reset done");
    // Every mode code, then every special immediate form
    for (int i = 0; i < 20; i++) rand_req(i < 16 ? 4'(i) : 4'h0, 2'(i));
    $display("test mode codes done");
    run_req(4'h4, 2'h0, 2'h0, 24'h0000ff, 0, 0, {32'h30, 16'hffc0, 48'h0});
    run_req(4'h5, 2'h1, 2'h0, 24'h00ff00, 0, 0, {32'h2, 16'h0, 16'h10, 32'h0});
    run_req(4'h8, 2'h0, 2'h0, 24'h0, 0, 0, {32'h10, 32'h0, 16'h8000, 16'h0});
    run_req(4'ha, 2'h0, 2'h0, 24'h80, 1, 0, {16'h10, 4'h5, 76'h0});
    run_req(4'hb, 2'h0, 2'h0, 24'h8000, 0, 0, {16'h10, 4'h5, 76'h0});
    run_req(4'h2, 2'h0, 2'h0, 24'h1234, 0, 0, {20'h0, 4'h3, 72'h0});
    run_req(4'h3, 2'h0, 2'h0, 24'h0fffff, 0, 0, 96'h0);
    run_req(4'h9, 2'h0, 2'h0, 24'h05, 0, 0, {32'h50, 16'hfffe, 48'h0});
    run_req(4'h1, 2'h0, 2'h0, 24'h0, 0, 20'h001ff, 96'h0);
    run_req(4'h0, 2'h0, 2'h0, 24'h0, 0, 20'h00200, 96'h0);
    run_req(4'h0, 2'h0, 2'h1, 24'h80, 0, 0, 96'h7fff);
    z_wr(20'hffff0);
    run_req(4'h6, 2'h2, 2'h0, 24'h000020, 0, 0, 96'h0);
    run_req(4'h4, 2'h2, 2'h0, 24'h0000ff, 0, 0, 96'h0);
    $display("test corner cases done");
    for (int i = 0; i < 300; i++) rand_req(4'($random(seed)), 2'($random(seed)));
    $display("test random requests done");
    finish_test();
  end
endmodule // tb_effective_address_generator
`default_nettype wire
